// File: include/alsc_defines.vh
`ifndef ALSC_DEFINES_VH
`define ALSC_DEFINES_VH

// ==========================================================
// Clock and timing
`define ALSC_CLK_MHZ 25
`define ALSC_TINT_SHORT_US 13700
`define ALSC_TINT_MID_US 101000
`define ALSC_TINT_LONG_US 402000
`define ALSC_BUS_STD_KHZ 100
`define ALSC_BUS_FAST_KHZ 400
`define ALSC_STRAP_WAIT 2'h3

// ==========================================================
// Integration time select codes
`define ALSC_TSEL_SHORT 2'h0
`define ALSC_TSEL_MID 2'h1
`define ALSC_TSEL_LONG 2'h2

// ==========================================================
// Converter
`define ALSC_GAIN_LO_STEP 17'h00001
`define ALSC_GAIN_HI_STEP 17'h00010
`define ALSC_FULL_SCALE 16'hffff

// ==========================================================
// Bus addresses (three-level strap) and SMBus alert response
`define ALSC_ADDR_LOW 7'h2a
`define ALSC_ADDR_FLOAT 7'h2b
`define ALSC_ADDR_HIGH 7'h2c
`define ALSC_ADDR_ALERT 7'h0c

// ==========================================================
// Write byte fields and byte counts
`define ALSC_CMD_CLEAR_BIT 6
`define ALSC_BITS_PER_BYTE 4'h8
`define ALSC_RD_BYTE_LAST 2'h3

// ==========================================================
// Synchroniser bit positions
`define ALSC_S_SCL 0
`define ALSC_S_SDA 1
`define ALSC_S_CH0 2
`define ALSC_S_CH1 3
`define ALSC_S_AHI 4
`define ALSC_S_ALO 5

`endif

// File: verilog/alsc_core.v
`timescale 1ns/1ns
`include "alsc_defines.vh"
// What this block does
// - Both channels integrate together, starting and stopping on the same cycle.
// - At the end of a conversion channel 0 loads data register zero and channel 1 register one.
// - Results are double-buffered so a bus read never sees a half-updated value.
// - The next integration starts right after the transfer, free-running while powered.
// - Upper and lower thresholds set by the host bound a window around the light level.
// - A completed conversion with channel 0 above the upper or below the lower threshold raises the interrupt.
// - A persistence count makes the interrupt wait for the out-of-window state to last.
// - On the plain two-wire variant the interrupt is a level held until firmware clears it.
// - On the SMBus variant the interrupt is an alert cleared by the alert response read.
// - The interrupt pin is open drain, pulled low only while asserted.
// - A three-level strap picks the slave address, high, low and floating being distinct.
// - The serial slave logic is the same on both variants apart from the SMBus alert response address, and runs at 100 kHz or 400 kHz on either.
// - Host-set gain and integration time scale the result and the conversion period.
// - The host can select power-down as well as active conversion.
module alsc_core #(
    parameter CNT_W = 24,
    parameter [31:0] INT_SHORT_CYC = `ALSC_TINT_SHORT_US * `ALSC_CLK_MHZ,
    parameter [31:0] INT_MID_CYC = `ALSC_TINT_MID_US * `ALSC_CLK_MHZ,
    parameter [31:0] INT_LONG_CYC = `ALSC_TINT_LONG_US * `ALSC_CLK_MHZ
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Configuration
    input wire power_on,
    input wire smbus_mode,
    input wire gain_high,
    input wire [1:0] integ_sel,
    input wire [15:0] thresh_low,
    input wire [15:0] thresh_high,
    input wire [3:0] persist,
    // Converter front end pulses and address strap sense
    input wire ch0_pulse,
    input wire ch1_pulse,
    input wire addr_sense_hi,
    input wire addr_sense_lo,
    // Serial bus
    input wire scl,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Interrupt pin
    output wire int_out,
    output wire int_oe,
    // Status
    output reg [15:0] ch0_data,
    output reg [15:0] ch1_data,
    output reg conv_done,
    output reg int_pending,
    output reg [6:0] dev_addr
);

    // ==========================================================
    // Input synchronisers
    reg [5:0] sync1;
    reg [5:0] sync2;
    reg [5:0] sync_prev;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 6'h3f;
            sync2 <= 6'h3f;
            sync_prev <= 6'h3f;
        end else begin
            sync1 <= {addr_sense_lo, addr_sense_hi, ch1_pulse, ch0_pulse, sda_in, scl};
            sync2 <= sync1;
            sync_prev <= sync2;
        end
    end

    // 25 MHz sampling leaves many clocks per bit even at fast-mode rate
    wire scl_rise = sync2[`ALSC_S_SCL] & ~sync_prev[`ALSC_S_SCL];
    wire scl_fall = ~sync2[`ALSC_S_SCL] & sync_prev[`ALSC_S_SCL];
    wire sda_s = sync2[`ALSC_S_SDA];
    wire bus_start = sync2[`ALSC_S_SCL] & sync_prev[`ALSC_S_SCL]
                     & ~sda_s & sync_prev[`ALSC_S_SDA];
    wire bus_stop = sync2[`ALSC_S_SCL] & sync_prev[`ALSC_S_SCL]
                    & sda_s & ~sync_prev[`ALSC_S_SDA];
    wire ch0_evt = sync2[`ALSC_S_CH0] & ~sync_prev[`ALSC_S_CH0];
    wire ch1_evt = sync2[`ALSC_S_CH1] & ~sync_prev[`ALSC_S_CH1];

    // ==========================================================
    // Address strap, caught once after reset release
    reg [1:0] strap_wait;
    reg strap_done;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
            dev_addr <= `ALSC_ADDR_FLOAT;
        end else if (!strap_done) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == `ALSC_STRAP_WAIT) begin
                strap_done <= 1'b1;
                if (sync2[`ALSC_S_AHI])
                    dev_addr <= `ALSC_ADDR_HIGH;
                else if (!sync2[`ALSC_S_ALO])
                    dev_addr <= `ALSC_ADDR_LOW;
                else
                    dev_addr <= `ALSC_ADDR_FLOAT;
            end
        end
    end

    // ==========================================================
    // Integrating converters
    reg [CNT_W-1:0] integ_cnt;
    reg [CNT_W-1:0] integ_last;
    reg [16:0] acc0;
    reg [16:0] acc1;

    always @* begin
        case (integ_sel)
            `ALSC_TSEL_SHORT: integ_last = INT_SHORT_CYC[CNT_W-1:0] - 1'b1;
            `ALSC_TSEL_MID: integ_last = INT_MID_CYC[CNT_W-1:0] - 1'b1;
            default: integ_last = INT_LONG_CYC[CNT_W-1:0] - 1'b1;
        endcase
    end

    wire [16:0] step = gain_high ? `ALSC_GAIN_HI_STEP : `ALSC_GAIN_LO_STEP;
    wire integ_end = power_on && (integ_cnt >= integ_last);
    wire [16:0] sum0 = acc0 + step;
    wire [16:0] sum1 = acc1 + step;
    wire [16:0] next_acc0 = (ch0_evt && !acc0[16]) ? sum0 : acc0;
    wire [16:0] next_acc1 = (ch1_evt && !acc1[16]) ? sum1 : acc1;
    // Overflow bit stands for saturation at full scale
    wire [15:0] res0 = acc0[16] ? `ALSC_FULL_SCALE : acc0[15:0];
    wire [15:0] res1 = acc1[16] ? `ALSC_FULL_SCALE : acc1[15:0];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            integ_cnt <= {CNT_W{1'b0}};
            acc0 <= 17'h00000;
            acc1 <= 17'h00000;
            ch0_data <= 16'h0000;
            ch1_data <= 16'h0000;
            conv_done <= 1'b0;
        end else begin
            conv_done <= integ_end;
            if (!power_on) begin
                integ_cnt <= {CNT_W{1'b0}};
                acc0 <= 17'h00000;
                acc1 <= 17'h00000;
            end else if (integ_end) begin
                // Shadow copy; bus reads use a separate snapshot as well
                ch0_data <= res0;
                ch1_data <= res1;
                integ_cnt <= {CNT_W{1'b0}};
                acc0 <= 17'h00000;
                acc1 <= 17'h00000;
            end else begin
                integ_cnt <= integ_cnt + 1'b1;
                acc0 <= next_acc0;
                acc1 <= next_acc1;
            end
        end
    end

    // ==========================================================
    // Threshold window and persistence on channel 0
    reg [3:0] pers_cnt;
    wire out_win = (res0 > thresh_high) || (res0 < thresh_low);
    wire [3:0] pers_inc = (pers_cnt == 4'hf) ? pers_cnt : pers_cnt + 4'h1;
    wire [3:0] pers_need = (persist == 4'h0) ? 4'h1 : persist;
    wire thr_event = integ_end && out_win && (pers_inc >= pers_need);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pers_cnt <= 4'h0;
        end else if (!power_on) begin
            pers_cnt <= 4'h0;
        end else if (integ_end) begin
            pers_cnt <= out_win ? pers_inc : 4'h0;
        end
    end

    // ==========================================================
    // Serial slave
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WDAT = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RDAT = 3'h5;
    localparam ST_HACK = 3'h6;

    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] rx;
    reg [7:0] tx;
    reg rd_mode;
    reg alert_rd;
    reg host_ack;
    reg drive_low;
    reg [1:0] rd_idx;
    reg [31:0] snap;
    reg bus_clear;

    wire own_hit = (rx[7:1] == dev_addr);
    wire alert_hit = smbus_mode && int_pending && rx[0]
                     && (rx[7:1] == `ALSC_ADDR_ALERT);
    wire [7:0] rd_byte = snap[{rd_idx, 3'h0} +: 8];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'hff;
            rd_mode <= 1'b0;
            alert_rd <= 1'b0;
            host_ack <= 1'b0;
            drive_low <= 1'b0;
            rd_idx <= 2'h0;
            snap <= 32'h00000000;
            bus_clear <= 1'b0;
        end else begin
            bus_clear <= 1'b0;
            if (bus_start) begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                drive_low <= 1'b0;
            end else if (bus_stop) begin
                state <= ST_IDLE;
                drive_low <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_WDAT: begin
                        if (scl_rise) begin
                            rx <= {rx[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == `ALSC_BITS_PER_BYTE) begin
                            bit_cnt <= 4'h0;
                            if (state == ST_WDAT) begin
                                state <= ST_WACK;
                                drive_low <= 1'b1;
                                bus_clear <= rx[`ALSC_CMD_CLEAR_BIT];
                            end else if (own_hit || alert_hit) begin
                                state <= ST_AACK;
                                drive_low <= 1'b1;
                                rd_mode <= rx[0];
                                alert_rd <= alert_hit;
                                rd_idx <= 2'h0;
                                // Freeze a coherent pair for the whole read
                                snap <= {ch1_data, ch0_data};
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            if (rd_mode) begin
                                state <= ST_RDAT;
                                tx <= alert_rd ? {dev_addr, 1'b0} : rd_byte;
                                drive_low <= alert_rd ? ~dev_addr[6] : ~rd_byte[7];
                                bus_clear <= alert_rd;
                            end else begin
                                state <= ST_WDAT;
                                drive_low <= 1'b0;
                            end
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            state <= ST_WDAT;
                            drive_low <= 1'b0;
                        end
                    end
                    ST_RDAT: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == `ALSC_BITS_PER_BYTE) begin
                                state <= ST_HACK;
                                bit_cnt <= 4'h0;
                                drive_low <= 1'b0;
                            end else begin
                                tx <= {tx[6:0], 1'b1};
                                drive_low <= ~tx[6];
                            end
                        end
                    end
                    ST_HACK: begin
                        if (scl_rise) begin
                            host_ack <= ~sda_s;
                        end else if (scl_fall) begin
                            if (host_ack) begin
                                state <= ST_RDAT;
                                rd_idx <= (rd_idx == `ALSC_RD_BYTE_LAST) ? 2'h0 : rd_idx + 2'h1;
                                tx <= snap[{rd_idx + 2'h1, 3'h0} +: 8];
                                drive_low <= ~snap[{rd_idx + 2'h1, 3'h0} + 5'h07];
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        drive_low <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = drive_low;

    // ==========================================================
    // Interrupt latch; a new event wins over a clear in the same cycle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            int_pending <= 1'b0;
        end else if (thr_event) begin
            int_pending <= 1'b1;
        end else if (bus_clear) begin
            int_pending <= 1'b0;
        end
    end

    // Open drain: only ever pulls low
    assign int_out = 1'b0;
    assign int_oe = int_pending;

endmodule

// File: test/alsc_core_asserts.sv
`timescale 1ns/1ns
`include "alsc_defines.vh"
module alsc_core_asserts #(
    parameter [31:0] INT_SHORT_CYC = 32'h0000003c,
    parameter [31:0] INT_MID_CYC = 32'h0000005a,
    parameter [31:0] INT_LONG_CYC = 32'h00000078
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Configuration and pins
    input wire power_on,
    input wire [1:0] integ_sel,
    input wire addr_sense_hi,
    input wire addr_sense_lo,
    input wire scl,
    input wire sda_out,
    input wire int_out,
    input wire int_oe,
    // Status
    input wire [15:0] ch0_data,
    input wire [15:0] ch1_data,
    input wire conv_done,
    input wire int_pending,
    input wire [6:0] dev_addr
);
// ==========================================
// Conversion spacing
logic [31:0] gap;
logic armed;
wire [31:0] exp_n = (integ_sel == `ALSC_TSEL_SHORT) ? INT_SHORT_CYC :
    (integ_sel == `ALSC_TSEL_MID) ? INT_MID_CYC : INT_LONG_CYC;
// Armed only after a full window, power-up phase is not fixed
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        gap <= 32'h0;
        armed <= 1'b0;
    end else if (!power_on) begin
        gap <= 32'h0;
        armed <= 1'b0;
    end else if (conv_done) begin
        gap <= 32'h1;
        armed <= 1'b1;
    end else begin
        gap <= gap + 32'h1;
    end
end
// ==========================================
// Properties
default clocking @(posedge clk); endclocking
default disable iff (!nrst);
sequence s_bus_idle;
    scl [*8];
endsequence
sequence s_powered_down;
    !power_on ##1 !power_on;
endsequence
sequence s_strap_high;
    (addr_sense_hi && !addr_sense_lo) [*8];
endsequence
a_pin_drain: assert property (
    int_oe == int_pending && !int_out && !sda_out) else $error("pin driven wrongly");
a_data_on_done: assert property (
    $changed(ch0_data) |-> conv_done) else $error("channel 0 changed outside load");
a_pair_load: assert property (
    $changed(ch1_data) |-> conv_done) else $error("channel 1 changed outside load");
a_done_single: assert property (
    conv_done |=> !conv_done) else $error("done longer than one cycle");
a_period_exact: assert property (
    conv_done && armed |-> gap == exp_n) else $error("conversion period wrong");
a_pd_silent: assert property (
    s_powered_down |-> !conv_done && !$rose(int_pending)) else $error("activity in power-down");
a_int_on_done: assert property (
    $rose(int_pending) |-> conv_done) else $error("interrupt without conversion");
a_int_held: assert property (
    s_bus_idle ##0 int_pending |=> int_pending) else $error("interrupt dropped on idle bus");
a_strap_high: assert property (
    s_strap_high |-> dev_addr == `ALSC_ADDR_HIGH) else $error("strap address wrong");
endmodule

bind alsc_core alsc_core_asserts #(.INT_SHORT_CYC(INT_SHORT_CYC), .INT_MID_CYC(INT_MID_CYC),
    .INT_LONG_CYC(INT_LONG_CYC)) u_alsc_core_asserts (
    .clk(clk), .nrst(nrst), .power_on(power_on), .integ_sel(integ_sel),
    .addr_sense_hi(addr_sense_hi), .addr_sense_lo(addr_sense_lo), .scl(scl),
    .sda_out(sda_out), .int_out(int_out), .int_oe(int_oe),
    .ch0_data(ch0_data), .ch1_data(ch1_data), .conv_done(conv_done),
    .int_pending(int_pending), .dev_addr(dev_addr));

// File: test/alsc_host.sv
`timescale 1ns/1ns
module alsc_host (
    // Clock for phase alignment
    input wire clk,
    // Bus wires
    input wire dev_pull,
    output reg scl,
    output wire sda
);
reg drv_low;
// Pull-up restores high when nobody pulls
assign sda = ~(drv_low | dev_pull);
initial begin
    scl = 1'b1;
    drv_low = 1'b0;
end
// ==========================================
// Frame steps, quarter of a 320 ns bit, kept off the clock edges
task start;
    @(posedge clk);
    #87 drv_low = 1'b1;
    #80 scl = 1'b0;
endtask
task stop;
    #80 drv_low = 1'b1;
    #80 scl = 1'b1;
    #80 drv_low = 1'b0;
    #80;
endtask
task bitx(input b, output r);
    #80 drv_low = !b;
    #80 scl = 1'b1;
    #80 r = sda;
    #80 scl = 1'b0;
endtask
task bytex(input [7:0] d, input a_in, output [7:0] q, output a_out);
    integer i;
    for (i = 7; i >= 0; i--) begin
        bitx(d[i], q[i]);
    end
    bitx(a_in, a_out);
endtask
endmodule

// File: test/test_alsc_core.sv
`timescale 1ns/1ns
`include "alsc_defines.vh"
module test_alsc_core;
reg clk = 1'b0, nrst = 1'b0, power_on = 1'b1, smbus_mode = 1'b0, gain_high = 1'b0;
reg [1:0] integ_sel = 2'h0;
reg [15:0] thresh_low = 16'h0000, thresh_high = 16'h0004;
reg [3:0] persist = 4'h2;
reg ch0_pulse = 1'b0, ch1_pulse = 1'b0, addr_sense_hi = 1'b1, addr_sense_lo = 1'b0;
wire scl, sda_in, sda_out, sda_oe, int_out, int_oe, conv_done, int_pending;
wire [15:0] ch0_data, ch1_data;
wire [6:0] dev_addr;
integer n_mismatch = 0, total_checks = 0;
reg [31:0] rv;
reg ak;
always #20 clk = ~clk;
alsc_core #(.INT_SHORT_CYC(32'h3c), .INT_MID_CYC(32'h5a), .INT_LONG_CYC(32'h78)) u_alsc_core (
    .clk(clk), .nrst(nrst), .power_on(power_on), .smbus_mode(smbus_mode),
    .gain_high(gain_high), .integ_sel(integ_sel), .thresh_low(thresh_low),
    .thresh_high(thresh_high), .persist(persist), .ch0_pulse(ch0_pulse),
    .ch1_pulse(ch1_pulse), .addr_sense_hi(addr_sense_hi), .addr_sense_lo(addr_sense_lo),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .int_out(int_out), .int_oe(int_oe), .ch0_data(ch0_data), .ch1_data(ch1_data),
    .conv_done(conv_done), .int_pending(int_pending), .dev_addr(dev_addr));
alsc_host u_alsc_host (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda(sda_in));
// ==========================================
// Tasks
task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
endtask
task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task wait_done;
    integer i;
    i = 0;
    @(negedge clk);
    while (conv_done !== 1'b1 && i < 400) begin
        @(negedge clk);
        i++;
    end
    if (i == 400) chk(32'h0, 32'h1);
endtask
// Front-end pulses, two cycles high and two low for the synchroniser
task pulses(input integer n0, input integer n1);
    integer i;
    for (i = 0; i < n0 || i < n1; i++) begin
        @(posedge clk);
        ch0_pulse <= (i < n0);
        ch1_pulse <= (i < n1);
        repeat (2) @(posedge clk);
        ch0_pulse <= 1'b0;
        ch1_pulse <= 1'b0;
        @(posedge clk);
    end
endtask
task bus_wr(input [6:0] a, input [7:0] d, output nak);
    reg [7:0] q;
    reg a2;
    u_alsc_host.start;
    u_alsc_host.bytex({a, 1'b0}, 1'b1, q, nak);
    if (!nak) u_alsc_host.bytex(d, 1'b1, q, a2);
    u_alsc_host.stop;
endtask
task bus_rd(input [6:0] a, input integer n, output [31:0] v, output nak);
    reg [7:0] q;
    reg x;
    integer k;
    v = 32'h0;
    u_alsc_host.start;
    u_alsc_host.bytex({a, 1'b1}, 1'b1, q, nak);
    for (k = 0; k < n; k++) begin
        u_alsc_host.bytex(8'hff, k == n - 1, q, x);
        v = {v[23:0], q};
    end
    u_alsc_host.stop;
endtask
// ==========================================
// Sequence
initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    wait_done;
    pulses(5, 3);
    wait_done;
    chk(ch0_data, 32'h5);
    chk(ch1_data, 32'h3);
    chk(int_pending, 32'h0);
    pulses(5, 0);
    wait_done;
    chk(int_pending, 32'h1);
    chk(int_oe, 32'h1);
    wait_done;
    chk(ch0_data, 32'h0);
    chk(int_pending, 32'h1);
    bus_wr(`ALSC_ADDR_LOW, 8'h40, ak);
    chk(ak, 32'h1);
    chk(int_pending, 32'h1);
    bus_wr(`ALSC_ADDR_HIGH, 8'h40, ak);
    chk(ak, 32'h0);
    chk(int_pending, 32'h0);
    wait_done;
    @(posedge clk);
    gain_high <= 1'b1;
    pulses(7, 2);
    wait_done;
    chk(ch0_data, 32'h70);
    chk(ch1_data, 32'h20);
    @(posedge clk);
    power_on <= 1'b0;
    // Pulses while powered down must be ignored
    pulses(9, 9);
    repeat (200) @(posedge clk);
    chk(int_pending, 32'h0);
    // No conversion may have loaded the powered-down pulses
    chk(ch0_data, 32'h70);
    bus_rd(`ALSC_ADDR_HIGH, 4, rv, ak);
    chk(ak, 32'h0);
    chk(rv, 32'h70002000);
    @(posedge clk);
    integ_sel <= `ALSC_TSEL_MID;
    smbus_mode <= 1'b1;
    gain_high <= 1'b0;
    power_on <= 1'b1;
    wait_done;
    pulses(5, 0);
    wait_done;
    pulses(5, 0);
    wait_done;
    chk(int_pending, 32'h1);
    bus_rd(`ALSC_ADDR_ALERT, 1, rv, ak);
    chk(ak, 32'h0);
    chk(rv, {24'h0, `ALSC_ADDR_HIGH, 1'b0});
    chk(int_pending, 32'h0);
    // Below the lower limit, persistence 0 acting as 1, plain variant
    @(posedge clk);
    thresh_low <= 16'h0002;
    persist <= 4'h0;
    smbus_mode <= 1'b0;
    wait_done;
    wait_done;
    chk(int_pending, 32'h1);
    chk(int_oe, 32'h1);
    // Alert response is refused on the plain variant
    bus_rd(`ALSC_ADDR_ALERT, 1, rv, ak);
    chk(ak, 32'h1);
    chk(int_pending, 32'h1);
    give_verdict;
end
// Watchdog, about five times the expected run
initial begin
    #400000;
    n_mismatch++;
    give_verdict;
end
endmodule
